/* File: design/monitor_pulse_defines.vh */
// Constants for the monitor pulse train and analog monitor generator.
// Included by every design file of the block; definitions only.
`ifndef MONITOR_PULSE_DEFINES_VH
`define MONITOR_PULSE_DEFINES_VH

// Pulse I/O selection codes
`define PIO_STD0        8'h00
`define PIO_STD1        8'h01
`define PIO_HALF10      8'h0a
`define PIO_HALF11      8'h0b
`define PIO_FIX20       8'h14
`define PIO_FIX21       8'h15
`define PIO_PASS100     8'h64
`define PIO_RESET       8'h00

// Function selection codes
`define FUNC_FREQ       8'h01
`define FUNC_CURRENT    8'h02
`define FUNC_TORQUE     8'h03
`define FUNC_REFOUT     8'h15

// Rates in pulses per second
`define STD_FULL_PPS    32'd1440
`define STD_MAX_PPS     32'd2400
`define HS_FULL_PPS     32'd50000
`define HS_MAX_PPS      32'd55000

// Clock and timing
`define CLK_HZ          32'd40000000
`define CLK_NS          32'd25
`define FIX_ON_NS       32'd10000
`define FIX_ON_CYC      (`FIX_ON_NS / `CLK_NS)
`define FILT_ZERO_NS    32'd4000000
`define FILT_ZERO_CYC   (`FILT_ZERO_NS / `CLK_NS)
`define FILT_RESET_MS   16'd10
`define CYC_PER_MS      32'd40000
`define FILT_MAX_MS     16'd5000

// Default calibrations and references
`define CAL_UNITY       16'h0100
`define TORQUE_REF_INIT 16'd150
`define TORQUE_REF_MAX  16'd400
`define AM_FULL_CODE    12'hfff

// Phase accumulator width: 40 MHz / 2^24 is about 2.4 pps step
`define ACC_W           24

`endif

/* File: design/rate_accumulator.v */
// Phase accumulator that turns a rate word into one-cycle pulse ticks.
// Assumes the rate word is stable or changes synchronously with mclk.
`timescale 1ns/1ps
`include "monitor_pulse_defines.vh"

module rate_accumulator #(
    parameter ACC_W = `ACC_W
) (
    input  wire             mclk,
    input  wire             nrst,
    input  wire [ACC_W-1:0] rateWord,
    output reg              tick,
    output reg              halfPhase
);
    reg  [ACC_W-1:0] phase;
    wire [ACC_W:0]   sum = {1'b0, phase} + {1'b0, rateWord};

    // Step is clock / 2^ACC_W, finer than 3 pps
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            phase     <= {ACC_W{1'b0}};
            tick      <= 1'b0;
            halfPhase <= 1'b0;
        end else begin
            phase     <= sum[ACC_W-1:0];
            tick      <= sum[ACC_W];
            halfPhase <= sum[ACC_W-1];
        end
    end
endmodule // rate_accumulator

/* File: design/analog_filter.v */
// Slew-limited response filter for the analog monitor code.
// Assumes a time constant in cycles supplied from the same clock domain.
`timescale 1ns/1ps
`include "monitor_pulse_defines.vh"

module analog_filter #(
    parameter W = 12
) (
    input  wire         mclk,
    input  wire         nrst,
    input  wire [W-1:0] target,
    input  wire [31:0]  stepCycles,
    output reg  [W-1:0] level
);
    reg [31:0] cnt;

    // One code step per interval: full swing spans roughly the set time
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt   <= 32'h0;
            level <= {W{1'b0}};
        end else if (cnt >= stepCycles) begin
            cnt <= 32'h0;
            if (level < target)
                level <= level + {{(W-1){1'b0}}, 1'b1};
            else if (level > target)
                level <= level - {{(W-1){1'b0}}, 1'b1};
        end else begin
            cnt <= cnt + 32'h1;
        end
    end
endmodule // analog_filter

/* File: design/monitor_pulse_train_output.v */
// Monitor pulse train and analog monitor generator.
// Assumes settings are driven synchronously by software logic on mclk;
// the pulse train input arrives from a pin and is synchronised here.
`timescale 1ns/1ps
`include "monitor_pulse_defines.vh"

// Overview of operation
// - Selection 0 or 1 drives standard rate pulses on the monitor terminal
// - Selections 10,11,20,21,100 drive high-speed pulses via open collector
// - Selections 10 and 11 give 50 percent duty square wave
// - Selections 20 and 21 give fixed on-time of about ten microseconds
// - Selection 100 passes the pulse train input through unchanged
// - High-speed mode maps 100 percent to 50k pulses per second
// - High-speed rate resolution no coarser than three pulses per second
// - Pulse width calibration ignored during any high-speed selection
// - All-clear returns pulse I/O selection to zero
// - Frequency monitor gives 1440 pps (50k high-speed) at reference
// - Rate saturates at 2400 pps standard, 55k pps high-speed
// - Current monitor gives 1440 pps at current reference
// - Torque monitor gives 1440 pps at torque reference
// - Analog level proportional, full code at reference, clamped at maximum
// - Analog response filter up to five seconds; zero means 4 ms
// - Function 21 emits constant 1440 pps reference output
// - Standard mode pulse width follows pulse calibration setting
// - Analog calibration scales gain, never beyond full code
// - Calibration accepted while running and in external mode
// - Torque reference accepts 0 to 400 percent, initial 150
// - Analog filter setting initialises to 0.01 s
module monitor_pulse_train_output #(
    parameter ACC_W = `ACC_W,
    parameter AM_W  = 12
) (
    input  wire             mclk,
    input  wire             nrst,
    input  wire             allClear,
    input  wire             setWrite,
    input  wire [7:0]       pulseIoSelectIn,
    input  wire [15:0]      torqueRefIn,
    input  wire [15:0]      filterMsIn,
    input  wire [7:0]       pulse_out_function_select,
    input  wire [7:0]       analog_out_function_select,
    input  wire [15:0]      freq_monitor_reference,
    input  wire [15:0]      current_monitor_reference,
    input  wire [15:0]      pulse_out_calibration,
    input  wire [15:0]      analog_out_calibration,
    input  wire [15:0]      freqValue,
    input  wire [15:0]      currentValue,
    input  wire [15:0]      torqueValue,
    input  wire             pulse_train_input_terminal,
    output reg              pulseMonitorOut,
    output reg              openCollectorOn,
    output reg              voltageMode,
    output reg  [7:0]       pulse_io_select,
    output reg  [15:0]      torque_monitor_reference,
    output reg  [15:0]      analog_out_filter,
    output wire [AM_W-1:0]  analog_monitor_terminal
);
    // Rate word for f pps: f * 2^ACC_W / CLK_HZ
    localparam [47:0] STD_FULL_W = (48'd1440 << ACC_W) / 48'd40000000;
    localparam [47:0] STD_MAX_W  = (48'd2400 << ACC_W) / 48'd40000000;
    localparam [47:0] HS_FULL_W  = (48'd50000 << ACC_W) / 48'd40000000;
    localparam [47:0] HS_MAX_W   = (48'd55000 << ACC_W) / 48'd40000000;
    localparam [31:0] FIX_ON     = `FIX_ON_CYC;
    // Standard mode on-width at unity calibration, about 0.2 ms
    localparam [31:0] STD_ON_BASE = 32'd8000;

    // Settings held by the block; writes accepted at any time except while allClear is asserted
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pulse_io_select          <= `PIO_RESET;
            torque_monitor_reference <= `TORQUE_REF_INIT;
            analog_out_filter        <= `FILT_RESET_MS;
        end else if (allClear) begin
            pulse_io_select          <= `PIO_RESET;
            torque_monitor_reference <= `TORQUE_REF_INIT;
            analog_out_filter        <= `FILT_RESET_MS;
        end else if (setWrite) begin
            pulse_io_select <= pulseIoSelectIn;
            if (torqueRefIn <= `TORQUE_REF_MAX)
                torque_monitor_reference <= torqueRefIn;
            if (filterMsIn <= `FILT_MAX_MS)
                analog_out_filter <= filterMsIn;
        end
    end

    // Pin input synchroniser
    reg pinMeta;
    reg pinSync;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pinMeta <= 1'b0;
            pinSync <= 1'b0;
        end else begin
            pinMeta <= pulse_train_input_terminal;
            pinSync <= pinMeta;
        end
    end

    // Active mode, latched at pulse boundaries only
    localparam M_STD  = 2'd0;
    localparam M_HALF = 2'd1;
    localparam M_FIX  = 2'd2;
    localparam M_PASS = 2'd3;
    reg  [1:0] mode;
    reg  [1:0] next_mode;
    always @* begin
        case (pulse_io_select)
            `PIO_HALF10, `PIO_HALF11: next_mode = M_HALF;
            `PIO_FIX20, `PIO_FIX21:   next_mode = M_FIX;
            `PIO_PASS100:             next_mode = M_PASS;
            default:                  next_mode = M_STD;
        endcase
    end
    wire highSpeed = (mode != M_STD);

    // Select monitored value and its reference
    reg [15:0] monValue;
    reg [15:0] monRef;
    reg        refOut;
    always @* begin
        monValue = freqValue;
        monRef   = freq_monitor_reference;
        refOut   = 1'b0;
        case (pulse_out_function_select)
            `FUNC_CURRENT: begin
                monValue = currentValue;
                monRef   = current_monitor_reference;
            end
            `FUNC_TORQUE: begin
                monValue = torqueValue;
                monRef   = torque_monitor_reference;
            end
            `FUNC_REFOUT: refOut = 1'b1;
            default: begin
                monValue = freqValue;
                monRef   = freq_monitor_reference;
            end
        endcase
    end

    // Proportional rate: full * value / reference, saturated
    wire [47:0] fullW = highSpeed ? HS_FULL_W : STD_FULL_W;
    wire [47:0] maxW  = highSpeed ? HS_MAX_W : STD_MAX_W;
    wire [47:0] scaled = (monRef == 16'h0) ? 48'h0 :
                         (fullW * {32'h0, monValue}) / {32'h0, monRef};
    reg  [47:0] rateSel;
    always @* begin
        if (refOut)
            rateSel = STD_FULL_W;
        else if (scaled > maxW)
            rateSel = maxW;
        else
            rateSel = scaled;
    end
    // Division is costly; register the rate to keep the path short
    reg [ACC_W-1:0] rateWord;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst)
            rateWord <= {ACC_W{1'b0}};
        else
            rateWord <= rateSel[ACC_W-1:0];
    end

    wire tick;
    wire halfPhase;
    rate_accumulator #(
        .ACC_W     (ACC_W)
    ) u_rate (
        .mclk      (mclk),
        .nrst      (nrst),
        .rateWord  (rateWord),
        .tick      (tick),
        .halfPhase (halfPhase)
    );

    // Standard on-width trimmed by calibration (unity = 0x0100)
    wire [47:0] stdOnFull = {16'h0, STD_ON_BASE} * {32'h0, pulse_out_calibration};
    wire [31:0] stdOn     = stdOnFull[39:8];

    // Pulse shaper; mode switches only while the output is low
    reg [31:0] onCnt;
    reg        busy;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mode            <= M_STD;
            onCnt           <= 32'h0;
            busy            <= 1'b0;
            pulseMonitorOut <= 1'b0;
        end else begin
            case (mode)
                M_HALF: begin
                    pulseMonitorOut <= (rateWord != {ACC_W{1'b0}}) & halfPhase;
                    busy            <= 1'b0;
                end
                M_PASS: begin
                    pulseMonitorOut <= pinSync;
                    busy            <= 1'b0;
                end
                M_FIX, M_STD: begin
                    if (tick && !busy) begin
                        busy            <= 1'b1;
                        pulseMonitorOut <= 1'b1;
                        onCnt           <= 32'h1;
                    end else if (busy) begin
                        // Calibration ignored in high-speed fixed width
                        if (onCnt >= ((mode == M_FIX) ? FIX_ON : stdOn)) begin
                            busy            <= 1'b0;
                            pulseMonitorOut <= 1'b0;
                        end
                        onCnt <= onCnt + 32'h1;
                    end
                end
                default: begin
                    busy            <= 1'b0;
                    pulseMonitorOut <= 1'b0;
                end
            endcase
            // Switch only in an idle cycle and hold low there, so no pulse
            // is started under one mode and ended under another
            if (!busy && !pulseMonitorOut && (next_mode != mode)) begin
                mode            <= next_mode;
                busy            <= 1'b0;
                pulseMonitorOut <= 1'b0;
            end
        end
    end

    // Drive stage: open collector in high speed, voltage output otherwise
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            openCollectorOn <= 1'b0;
            voltageMode     <= 1'b1;
        end else begin
            openCollectorOn <= highSpeed & pulseMonitorOut;
            voltageMode     <= ~highSpeed;
        end
    end

    // Analog path: value / reference * full code * gain, clamped
    reg [15:0] amValue;
    reg [15:0] amRef;
    reg        amRefOut;
    always @* begin
        amValue  = freqValue;
        amRef    = freq_monitor_reference;
        amRefOut = 1'b0;
        case (analog_out_function_select)
            `FUNC_CURRENT: begin
                amValue = currentValue;
                amRef   = current_monitor_reference;
            end
            `FUNC_TORQUE: begin
                amValue = torqueValue;
                amRef   = torque_monitor_reference;
            end
            `FUNC_REFOUT: amRefOut = 1'b1;
            default: begin
                amValue = freqValue;
                amRef   = freq_monitor_reference;
            end
        endcase
    end
    wire [47:0] amRaw = amRefOut ? {36'h0, `AM_FULL_CODE} :
                        (amRef == 16'h0) ? 48'h0 :
                        ({36'h0, `AM_FULL_CODE} * {32'h0, amValue}) / {32'h0, amRef};
    wire [63:0] amGain = {16'h0, amRaw} * {48'h0, analog_out_calibration};
    wire [55:0] amScaled = amGain[63:8];
    reg  [AM_W-1:0] amTarget;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst)
            amTarget <= {AM_W{1'b0}};
        else if (amScaled > {44'h0, `AM_FULL_CODE})
            amTarget <= `AM_FULL_CODE;
        else
            amTarget <= amScaled[AM_W-1:0];
    end

    // Step interval: set time spread over the full code swing; zero -> 4 ms
    wire [47:0] filtCyc = (analog_out_filter == 16'h0) ? {16'h0, `FILT_ZERO_CYC} :
                          {32'h0, analog_out_filter} * {16'h0, `CYC_PER_MS};
    wire [47:0] stepFull = filtCyc / 48'd4096;
    reg  [31:0] stepCycles;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst)
            stepCycles <= 32'h0;
        else
            stepCycles <= stepFull[31:0];
    end

    analog_filter #(
        .W          (AM_W)
    ) u_filter (
        .mclk       (mclk),
        .nrst       (nrst),
        .target     (amTarget),
        .stepCycles (stepCycles),
        .level      (analog_monitor_terminal)
    );
endmodule // monitor_pulse_train_output

/* File: verification/monitor_pulse_checker_assertions.sv */
// Concurrent checks on the monitor pulse generator's top-level ports.
// Assumes one mclk domain with nrst as its asynchronous active-low reset.
`timescale 1ns/1ps
`include "monitor_pulse_defines.vh"
module monitor_pulse_checker #(
    parameter AM_W = 12
) (
    input wire            mclk,
    input wire            nrst,
    input wire            allClear,
    input wire            setWrite,
    input wire [7:0]      pulseIoSelectIn,
    input wire [15:0]     torqueRefIn,
    input wire [15:0]     filterMsIn,
    input wire            pulse_train_input_terminal,
    input wire            pulseMonitorOut,
    input wire            openCollectorOn,
    input wire            voltageMode,
    input wire [7:0]      pulse_io_select,
    input wire [15:0]     torque_monitor_reference,
    input wire [15:0]     analog_out_filter,
    input wire [AM_W-1:0] analog_monitor_terminal
);
    reg [31:0] hiLen;
    reg [7:0]  selRise;
    reg [7:0]  selLast;
    reg [2:0]  passCnt;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    sequence sClr;
        allClear;
    endsequence
    sequence sSet;
        setWrite && !allClear;
    endsequence
    // A pulse starts under the selection seen one cycle before its first high sample
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hiLen   <= 32'h0;
            selRise <= 8'h00;
            selLast <= 8'h00;
            passCnt <= 3'h0;
        end else begin
            hiLen   <= pulseMonitorOut ? hiLen + 32'h1 : 32'h0;
            selLast <= pulse_io_select;
            if (pulseMonitorOut && hiLen == 32'h0)
                selRise <= selLast;
            // Pass-through begins at the first idle cycle under selection 100
            if (pulse_io_select != `PIO_PASS100)
                passCnt <= 3'h0;
            else if ((passCnt != 3'h0 || !pulseMonitorOut) && passCnt != 3'h7)
                passCnt <= passCnt + 3'h1;
        end
    end
    a_clear_select: assert property (sClr |=> pulse_io_select == `PIO_RESET)
        else $error("select not cleared");
    a_clear_torque: assert property (sClr |=>
        torque_monitor_reference == `TORQUE_REF_INIT) else $error("torque ref not restored");
    a_clear_filter: assert property (sClr |=>
        analog_out_filter == `FILT_RESET_MS) else $error("filter not restored");
    a_write_select: assert property (sSet |=>
        pulse_io_select == $past(pulseIoSelectIn)) else $error("select not loaded");
    a_torque_limit: assert property (sSet ##0 torqueRefIn > `TORQUE_REF_MAX |=>
        $stable(torque_monitor_reference)) else $error("torque ref over range stored");
    a_filter_limit: assert property (sSet ##0 filterMsIn > `FILT_MAX_MS |=>
        $stable(analog_out_filter)) else $error("filter over range stored");
    a_oc_follow: assert property (openCollectorOn |->
        $past(pulseMonitorOut) && !$past(voltageMode)) else $error("transistor on outside pulse");
    a_oc_drive: assert property (pulseMonitorOut && !voltageMode |=> openCollectorOn)
        else $error("transistor off during pulse");
    a_am_slew: assert property (analog_monitor_terminal <= $past(analog_monitor_terminal) + 1 &&
        analog_monitor_terminal + 1 >= $past(analog_monitor_terminal)) else $error("analog jump");
    a_fixed_width: assert property ($fell(pulseMonitorOut) &&
        (selRise == `PIO_FIX20 || selRise == `PIO_FIX21) |-> hiLen >= 32'd400 && hiLen <= 32'd402)
        else $error("fixed on-width wrong");
    a_pass_thru: assert property (pulse_io_select == `PIO_PASS100 &&
        passCnt >= 3'h2 |->
        pulseMonitorOut == $past(pulse_train_input_terminal, 3)) else $error("pass-through wrong");
endmodule // monitor_pulse_checker

bind monitor_pulse_train_output monitor_pulse_checker #(.AM_W(AM_W)) chk (
    .mclk(mclk), .nrst(nrst), .allClear(allClear), .setWrite(setWrite),
    .pulseIoSelectIn(pulseIoSelectIn), .torqueRefIn(torqueRefIn), .filterMsIn(filterMsIn),
    .pulse_train_input_terminal(pulse_train_input_terminal),
    .pulseMonitorOut(pulseMonitorOut), .openCollectorOn(openCollectorOn),
    .voltageMode(voltageMode), .pulse_io_select(pulse_io_select),
    .torque_monitor_reference(torque_monitor_reference),
    .analog_out_filter(analog_out_filter), .analog_monitor_terminal(analog_monitor_terminal));

/* File: verification/pulse_meter_model.sv */
// Behavioural pulse counter and period meter on the monitor output.
// Assumes the pulse line is registered on mclk; all figures are in mclk cycles.
`timescale 1ns/1ps
module pulse_meter_model (
    input  wire        mclk,
    input  wire        pulse,
    output reg  [31:0] riseCnt,
    output reg  [31:0] period,
    output reg  [31:0] hiWidth
);
    reg [31:0] sinceRise;
    reg [31:0] hiRun;
    reg        last;
    initial begin
        {riseCnt, period, hiWidth, sinceRise, hiRun} = 160'h0;
        last = 1'b0;
    end
    // A real counter only sees edges, so width and period are per complete pulse
    always @(posedge mclk) begin
        last <= pulse;
        sinceRise <= sinceRise + 32'h1;
        if (pulse)
            hiRun <= hiRun + 32'h1;
        if (pulse && !last) begin
            riseCnt <= riseCnt + 32'h1;
            period <= sinceRise;
            hiWidth <= hiRun;
            sinceRise <= 32'h1;
            hiRun <= 32'h1;
        end
    end
endmodule // pulse_meter_model

/* File: verification/tb_monitor_pulse_train_output.sv */
// Self-checking bench for the monitor pulse generator.
// Assumes inputs move 1 ns after each rising mclk edge; a meter model watches the output.
`timescale 1ns/1ps
`include "monitor_pulse_defines.vh"
`define CHK(nm, ex, got) begin \
    comparisons++; \
    if ((got) !== (ex)) begin \
        errorCnt++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module tb_monitor_pulse_train_output;
    reg         mclk = 1'b0;
    reg         nrst, allClear, setWrite, pinIn;
    reg  [7:0]  selIn, pulseFunc, amFunc;
    reg  [15:0] torqIn, filtIn, freqRef, curRef, pulseCal, amCal, freqVal, curVal, torqVal;
    wire        pulseOut, ocOn, voltageMode;
    wire [7:0]  selOut;
    wire [15:0] torqRef, filtOut;
    wire [11:0] amLevel;
    wire [31:0] riseCnt, period, hiWidth;
    integer     errorCnt = 0;
    integer     comparisons = 0;
    integer     i, n, refV, valV;
    always #12.5 mclk = ~mclk;
    monitor_pulse_train_output dut (
        .mclk(mclk), .nrst(nrst), .allClear(allClear), .setWrite(setWrite),
        .pulseIoSelectIn(selIn), .torqueRefIn(torqIn), .filterMsIn(filtIn),
        .pulse_out_function_select(pulseFunc), .analog_out_function_select(amFunc),
        .freq_monitor_reference(freqRef), .current_monitor_reference(curRef),
        .pulse_out_calibration(pulseCal), .analog_out_calibration(amCal),
        .freqValue(freqVal), .currentValue(curVal), .torqueValue(torqVal),
        .pulse_train_input_terminal(pinIn), .pulseMonitorOut(pulseOut),
        .openCollectorOn(ocOn), .voltageMode(voltageMode), .pulse_io_select(selOut),
        .torque_monitor_reference(torqRef), .analog_out_filter(filtOut),
        .analog_monitor_terminal(amLevel));
    pulse_meter_model meter (.mclk(mclk), .pulse(pulseOut), .riseCnt(riseCnt),
        .period(period), .hiWidth(hiWidth));
    function [31:0] expPer(input [31:0] pps);
        reg [63:0] rw;
        rw = ({32'h0, pps} << 24) / 64'd40000000;
        expPer = 64'h1000000 / rw;
    endfunction
    function [31:0] hsPps(input [31:0] v, input [31:0] r);
        hsPps = v * `HS_FULL_PPS / r;
        if (hsPps > `HS_MAX_PPS)
            hsPps = `HS_MAX_PPS;
    endfunction
    // Meter readings jitter by a cycle, so periods are compared with a margin
    function bit near(input [31:0] s, input [31:0] e);
        near = (s > e ? s - e : e - s) <= e / 256 + 2;
    endfunction
    task testDone;
        $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task step(input integer k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task endTest(input string nm);
        $display("test %s finished", nm);
    endtask
    task wr(input [7:0] s, input [15:0] t, input [15:0] f);
        selIn = s;
        torqIn = t;
        filtIn = f;
        setWrite = 1'b1;
        step(1);
        setWrite = 1'b0;
        step(1);
    endtask
    task rises(input integer k, input integer lim);
        integer c0;
        integer t;
        c0 = riseCnt;
        t = 0;
        while (riseCnt < c0 + k && t < lim) begin
            step(1);
            t++;
        end
        if (t >= lim) begin
            errorCnt++;
            $display("CHECK FAILED riseWait expected %0d seen %0d", k, riseCnt - c0);
            testDone();
        end
    endtask
    initial begin
        {nrst, allClear, setWrite, pinIn} = 4'b0000;
        {selIn, torqIn, filtIn} = 40'h0;
        {pulseFunc, amFunc} = {`FUNC_REFOUT, `FUNC_FREQ};
        {freqRef, freqVal, curRef, curVal, torqVal} = {16'd16, 16'd1, 48'h0};
        {pulseCal, amCal} = {16'h0080, `CAL_UNITY};
        n = $urandom(32'had9e);
        step(20);
        nrst = 1'b1;
        step(1);
        `CHK("selReset", `PIO_RESET, selOut)
        `CHK("torqueReset", `TORQUE_REF_INIT, torqRef)
        `CHK("filterReset", `FILT_RESET_MS, filtOut)
        `CHK("voltReset", 1'b1, voltageMode)
        wr(`PIO_STD1, 16'd401, 16'd5001);
        `CHK("torqueKeep", `TORQUE_REF_INIT, torqRef)
        `CHK("filterKeep", `FILT_RESET_MS, filtOut)
        `CHK("selStd", `PIO_STD1, selOut)
        wr(`PIO_STD1, `TORQUE_REF_MAX, 16'h0);
        `CHK("torqueMax", `TORQUE_REF_MAX, torqRef)
        `CHK("filterZero", 16'h0, filtOut)
        endTest("settings");
        step(5000);
        `CHK("amMid", 1'b1, amLevel > 12'd115 && amLevel < 12'd140)
        rises(2, 70000);
        `CHK("stdPeriod", 1'b1, near(period, expPer(`STD_FULL_PPS)))
        `CHK("stdWidth", 1'b1, near(hiWidth, 32'd4000))
        `CHK("amFull", 1'b1, near(amLevel, 32'd255))
        amCal = 16'h0200;
        freqRef = 16'd32;
        step(100);
        `CHK("amGain", 1'b1, near(amLevel, 32'd255))
        endTest("standard");
        {freqRef, curRef, freqVal, curVal, torqVal} = {5{16'd100}};
        wr(($urandom % 2) ? `PIO_FIX20 : `PIO_FIX21, 16'd100, 16'h0);
        for (i = 1; i <= 3; i++) begin
            pulseFunc = i[7:0];
            rises(3, 40000);
            `CHK("hsPeriod", 1'b1, near(period, expPer(`HS_FULL_PPS)))
            `CHK("fixWidth", 1'b1, near(hiWidth, `FIX_ON_CYC))
            `CHK("hsMode", 1'b0, voltageMode)
        end
        {pulseFunc, freqVal} = {`FUNC_FREQ, 16'd300};
        rises(3, 40000);
        `CHK("hsCap", 1'b1, near(period, expPer(`HS_MAX_PPS)))
        for (i = 0; i < 6; i++) begin
            wr(($urandom % 2) ? `PIO_HALF10 : `PIO_HALF11, 16'd100, 16'h0);
            refV = 100 + $urandom % 900;
            valV = (i == 0) ? refV : refV / 2 + $urandom % (refV / 2 + 1);
            freqRef = refV[15:0];
            freqVal = valV[15:0];
            rises(3, 40000);
            `CHK("hsRate", 1'b1, near(period, expPer(hsPps(valV, refV))))
            n = hiWidth * 2 - period;
            `CHK("duty", 1'b1, n >= -3 && n <= 3)
        end
        endTest("highSpeed");
        for (i = 0; i < 2; i++) begin
            freqVal = i ? 16'd50 : 16'd0;
            freqRef = i ? 16'd0 : 16'd100;
            step(2000);
            n = riseCnt;
            step(4000);
            `CHK("noPulse", n, riseCnt)
        end
        wr(`PIO_PASS100, 16'd100, 16'h0);
        step(10);
        n = riseCnt;
        for (i = 0; i < 20; i++) begin
            pinIn = ~pinIn;
            step(3 + $urandom % 8);
        end
        step(10);
        `CHK("passRises", n + 10, riseCnt)
        endTest("passThrough");
        {allClear, setWrite, selIn} = {2'b11, `PIO_HALF10};
        step(1);
        {allClear, setWrite} = 2'b00;
        step(1);
        `CHK("selClear", `PIO_RESET, selOut)
        `CHK("torqueClear", `TORQUE_REF_INIT, torqRef)
        `CHK("filterClear", `FILT_RESET_MS, filtOut)
        step(10);
        `CHK("voltBack", 1'b1, voltageMode)
        endTest("allClear");
        testDone();
    end
endmodule // tb_monitor_pulse_train_output
